// file: hdl/asrms_pkg.sv
// Constants for the serial readout and mode select block
package asrms_pkg;
  localparam int unsigned RESULT_W       = 18;
  localparam int unsigned CNT_W          = 5;
  localparam int unsigned SYS_CLK_PER_NS = 40;
  // Conversion time window, nanoseconds
  localparam int unsigned CONV_MIN_NS    = 500;
  localparam int unsigned CONV_MAX_NS    = 3700;
  // Least time rounds up, longest rounds down
  localparam int unsigned CONV_MIN_CYC   = (CONV_MIN_NS + SYS_CLK_PER_NS - 1) / SYS_CLK_PER_NS;
  localparam int unsigned CONV_MAX_CYC   = CONV_MAX_NS / SYS_CLK_PER_NS;
  localparam logic [CNT_W-1:0] CONV_CYC  = CNT_W'(CONV_MIN_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;
  localparam logic [CNT_W-1:0] LAST_BIT  = CNT_W'(RESULT_W - 1);
  localparam logic [RESULT_W-1:0] RES_ZERO = 18'h0_0000;
  localparam logic [RESULT_W-1:0] RES_ONE  = 18'h0_0001;
  // Conversion state, one-hot
  typedef enum logic [1:0] {
    ASRMS_ACQ  = 2'b01,
    ASRMS_CONV = 2'b10
  } asrms_state_e;
endpackage

// file: hdl/asrms_top.sv
// Serial readout and mode selection of an 18-bit sampling converter
`timescale 1ns/10ps
module asrms_top (
  input  wire logic                          sys_clk,
  input  wire logic                          srst,
  input  wire logic                          shift_clock,
  input  wire logic                          convert_strobe,
  input  wire logic                          serial_in,
  input  wire logic [asrms_pkg::RESULT_W-1:0] sample_code,
  output logic                               serial_out,
  output logic                               serial_out_oe,
  output logic                               conv_busy
);

  // Pin synchronisers into sys_clk
  logic cnv_s1_reg, cnv_s2_reg, cnv_s3_reg;
  logic sdi_s1_reg, sdi_s2_reg;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnv_s1_reg <= 1'b0;
      cnv_s2_reg <= 1'b0;
      cnv_s3_reg <= 1'b0;
      sdi_s1_reg <= 1'b1;
      sdi_s2_reg <= 1'b1;
    end else begin
      cnv_s1_reg <= convert_strobe;
      cnv_s2_reg <= cnv_s1_reg;
      cnv_s3_reg <= cnv_s2_reg;
      sdi_s1_reg <= serial_in;
      sdi_s2_reg <= sdi_s1_reg;
    end
  end
  logic cnv_rise;
  assign cnv_rise = cnv_s2_reg & ~cnv_s3_reg;

  // Conversion controller
  asrms_pkg::asrms_state_e state_reg, state_next;
  logic [asrms_pkg::CNT_W-1:0]    cnt_reg, cnt_next;
  logic                           chain_reg, chain_next;
  logic                           busy_en_reg, busy_en_next;
  logic [asrms_pkg::RESULT_W-1:0] code_reg, code_next;
  logic                           done_tgl_reg, done_tgl_next;
  logic                           conv_busy_next;

  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    chain_next     = chain_reg;
    busy_en_next   = busy_en_reg;
    code_next      = code_reg;
    done_tgl_next  = done_tgl_reg;
    conv_busy_next = 1'b0;
    unique case (state_reg)
      asrms_pkg::ASRMS_ACQ: begin
        if (cnv_rise) begin
          state_next   = asrms_pkg::ASRMS_CONV;
          chain_next   = ~sdi_s2_reg;
          busy_en_next = 1'b0;
          cnt_next     = asrms_pkg::CONV_CYC;
          // Busy rises with the state so its width equals the count
          conv_busy_next = 1'b1;
        end
      end
      asrms_pkg::ASRMS_CONV: begin
        conv_busy_next = 1'b1;
        cnt_next = cnt_reg - asrms_pkg::CNT_ONE;
        if (cnt_reg == asrms_pkg::CNT_ONE) begin
          state_next     = asrms_pkg::ASRMS_ACQ;
          code_next      = sample_code;
          done_tgl_next  = ~done_tgl_reg;
          conv_busy_next = 1'b0;
          // Busy indicator armed only in framed mode
          busy_en_next   = ~chain_reg & (~cnv_s2_reg | ~sdi_s2_reg);
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg    <= asrms_pkg::ASRMS_ACQ;
      cnt_reg      <= asrms_pkg::CNT_ZERO;
      chain_reg    <= 1'b0;
      busy_en_reg  <= 1'b0;
      code_reg     <= asrms_pkg::RES_ZERO;
      done_tgl_reg <= 1'b0;
      conv_busy    <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      chain_reg    <= chain_next;
      busy_en_reg  <= busy_en_next;
      code_reg     <= code_next;
      done_tgl_reg <= done_tgl_next;
      conv_busy    <= conv_busy_next;
    end
  end

  // Output enable in sys_clk; framed mode drives only while either input low
  logic sel_lvl;
  assign sel_lvl = ~chain_reg & (~cnv_s2_reg | ~sdi_s2_reg);

  // Link domain: toggle and levels resynchronised; code_reg stable
  // long before a load because conversion ends before any read starts
  logic tgl_l1_reg, tgl_l2_reg, tgl_l3_reg;
  logic chain_l1_reg, chain_l2_reg;
  logic sel_l1_reg, sel_l2_reg;
  logic [asrms_pkg::RESULT_W-1:0] shreg_reg, shreg_next;
  logic [asrms_pkg::CNT_W-1:0]    bit_reg, bit_next;
  logic                           so_next, oe_next;

  always_comb begin
    shreg_next = shreg_reg;
    bit_next   = bit_reg;
    if (tgl_l2_reg != tgl_l3_reg) begin
      shreg_next = code_reg;
      bit_next   = asrms_pkg::CNT_ZERO;
    end else if (chain_l2_reg) begin
      // 18-stage chain, serial_in enters at the bottom
      shreg_next = {shreg_reg[asrms_pkg::RESULT_W-2:0], serial_in};
    end else if (sel_l2_reg && bit_reg <= asrms_pkg::LAST_BIT) begin
      shreg_next = {shreg_reg[asrms_pkg::RESULT_W-2:0], 1'b0};
      bit_next   = bit_reg + asrms_pkg::CNT_ONE;
    end
    so_next = shreg_next[asrms_pkg::RESULT_W-1];
    oe_next = chain_l2_reg | (sel_l2_reg & (bit_next <= asrms_pkg::LAST_BIT));
  end

  // Bits change on falling shift_clock edges
  always_ff @(negedge shift_clock) begin
    tgl_l1_reg   <= done_tgl_reg;
    tgl_l2_reg   <= tgl_l1_reg;
    tgl_l3_reg   <= tgl_l2_reg;
    chain_l1_reg <= chain_reg;
    chain_l2_reg <= chain_l1_reg;
    sel_l1_reg   <= sel_lvl;
    sel_l2_reg   <= sel_l1_reg;
    shreg_reg    <= shreg_next;
    bit_reg      <= bit_next;
  end

  // Output mux in sys_clk; link state resynchronised there
  logic so_s1_reg, so_s2_reg, oe_s1_reg, oe_s2_reg;
  logic so_l_reg, oe_l_reg;
  always_ff @(negedge shift_clock) begin
    so_l_reg <= so_next;
    oe_l_reg <= oe_next;
  end
  logic serial_out_next, serial_out_oe_next;
  always_comb begin
    if (busy_en_reg && state_reg == asrms_pkg::ASRMS_ACQ && sel_lvl && ~oe_s2_reg) begin
      serial_out_next    = 1'b1;
      serial_out_oe_next = 1'b1;
    end else if (state_reg == asrms_pkg::ASRMS_CONV && sel_lvl) begin
      serial_out_next    = 1'b0;
      serial_out_oe_next = 1'b1;
    end else begin
      serial_out_next    = so_s2_reg;
      serial_out_oe_next = oe_s2_reg & (chain_reg | sel_lvl);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      so_s1_reg     <= 1'b0;
      so_s2_reg     <= 1'b0;
      oe_s1_reg     <= 1'b0;
      oe_s2_reg     <= 1'b0;
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      so_s1_reg     <= so_l_reg;
      so_s2_reg     <= so_s1_reg;
      oe_s1_reg     <= oe_l_reg;
      oe_s2_reg     <= oe_s1_reg;
      serial_out    <= serial_out_next;
      serial_out_oe <= serial_out_oe_next;
    end
  end

  // Check helper: length of the current busy run
  logic [asrms_pkg::CNT_W-1:0] busy_run_reg, busy_run_next;
  always_comb begin
    busy_run_next = conv_busy ? (busy_run_reg + asrms_pkg::CNT_ONE) : asrms_pkg::CNT_ZERO;
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_run_reg <= asrms_pkg::CNT_ZERO;
    end else begin
      busy_run_reg <= busy_run_next;
    end
  end

  // Checks
  property p_conv_len;
    @(posedge sys_clk) disable iff (srst)
      $fell(conv_busy) |-> (busy_run_reg == asrms_pkg::CONV_CYC);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_busy_start;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == asrms_pkg::ASRMS_ACQ && cnv_rise) |=> conv_busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy did not start");

  property p_busy_max;
    @(posedge sys_clk) disable iff (srst)
      conv_busy |-> (busy_run_reg < asrms_pkg::CONV_CYC);
  endproperty
  a_busy_max: assert property (p_busy_max) else $error("busy run too long");

  // Link side checks; no link reset, so antecedents stay unknown until flushed
  property p_load_top;
    @(negedge shift_clock) disable iff (srst)
      (tgl_l2_reg != tgl_l3_reg) |=> (shreg_reg == code_reg);
  endproperty
  a_load_top: assert property (p_load_top) else $error("result not loaded for shift");

  property p_bit_step;
    @(negedge shift_clock) disable iff (srst)
      (tgl_l2_reg == tgl_l3_reg && !chain_l2_reg && sel_l2_reg
       && bit_reg <= asrms_pkg::LAST_BIT) |=> (bit_reg == $past(bit_reg) + asrms_pkg::CNT_ONE);
  endproperty
  a_bit_step: assert property (p_bit_step) else $error("bit count did not advance");

  property p_chain_shift;
    @(negedge shift_clock) disable iff (srst)
      (tgl_l2_reg == tgl_l3_reg && chain_l2_reg) |=> (shreg_reg[0] == $past(serial_in));
  endproperty
  a_chain_shift: assert property (p_chain_shift) else $error("chain input not taken");

  property p_start;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == asrms_pkg::ASRMS_ACQ && cnv_rise) |=> state_reg == asrms_pkg::ASRMS_CONV;
  endproperty
  a_start: assert property (p_start) else $error("edge did not start conversion");

  property p_chain_sel;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == asrms_pkg::ASRMS_ACQ && cnv_rise && !sdi_s2_reg) |=> chain_reg;
  endproperty
  a_chain_sel: assert property (p_chain_sel) else $error("chain mode not selected");

  property p_cs_sel;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == asrms_pkg::ASRMS_ACQ && cnv_rise && sdi_s2_reg) |=> !chain_reg;
  endproperty
  a_cs_sel: assert property (p_cs_sel) else $error("framed mode not selected");

  property p_mode_hold;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == asrms_pkg::ASRMS_CONV) |=> $stable(chain_reg);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed mid conversion");

  property p_busy_low;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == asrms_pkg::ASRMS_CONV && sel_lvl) |=> (serial_out_oe && !serial_out);
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy low not shown");

  property p_load;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == asrms_pkg::ASRMS_CONV && cnt_reg == asrms_pkg::CNT_ONE)
      |=> (code_reg == $past(sample_code) && state_reg == asrms_pkg::ASRMS_ACQ);
  endproperty
  a_load: assert property (p_load) else $error("code not loaded at completion");

  property p_release;
    @(posedge sys_clk) disable iff (srst)
      (!chain_reg && !sel_lvl) |=> !serial_out_oe;
  endproperty
  a_release: assert property (p_release) else $error("output not released");

  property p_busy_arm;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == asrms_pkg::ASRMS_CONV && cnt_reg == asrms_pkg::CNT_ONE && chain_reg)
      |=> !busy_en_reg;
  endproperty
  a_busy_arm: assert property (p_busy_arm) else $error("busy armed in chain mode");

  c_chain: cover property (@(posedge sys_clk) disable iff (srst) cnv_rise && !sdi_s2_reg);
  c_framed: cover property (@(posedge sys_clk) disable iff (srst) cnv_rise && sdi_s2_reg);
  c_busy: cover property (@(posedge sys_clk) disable iff (srst) busy_en_reg && serial_out);
  c_load: cover property (@(negedge shift_clock) tgl_l2_reg != tgl_l3_reg);

endmodule // asrms_top

// file: test/asrms_host_model.sv
// Host side model: strobe, select or chain data input, gated shift clock
`timescale 1ns/10ps
module asrms_host_model (
  output logic       convert_strobe,
  output logic       serial_in,
  output logic       shift_clock,
  input  wire logic  serial_out
);
  logic [35:0] q;
  initial begin
    convert_strobe = 1'b0;
    serial_in      = 1'b1;
    shift_clock    = 1'b1;
  end
  // Clock stands high between frames; output sampled just before each fall
  task automatic shift(input int n, input logic [35:0] d);
    for (int i = 0; i < n; i++) begin
      serial_in = d[i];
      #75 q[i] = serial_out;
      #5 shift_clock = 1'b0;
      #80 shift_clock = 1'b1;
    end
  endtask
  // Select level settles before the strobe moves
  task automatic strobe(input logic lvl, input logic sel);
    serial_in = sel;
    #7 convert_strobe = lvl;
  endtask
endmodule // asrms_host_model

// file: test/test_asrms_top.sv
// Self-checking bench for the serial readout and mode select block
`timescale 1ns/10ps
module test_asrms_top;
  logic        sys_clk     = 1'b0;
  logic        srst        = 1'b1;
  logic [17:0] sample_code = 18'h0_0000;
  wire         shift_clock;
  wire         convert_strobe;
  wire         serial_in;
  logic        serial_out;
  logic        serial_out_oe;
  logic        conv_busy;
  int          fails       = 0;
  int          check_count = 0;
  int          cycles      = 0;
  always #20 sys_clk = ~sys_clk;
  asrms_host_model u_host (.convert_strobe(convert_strobe), .serial_in(serial_in),
    .shift_clock(shift_clock), .serial_out(serial_out));
  asrms_top u_dut (.sys_clk(sys_clk), .srst(srst), .shift_clock(shift_clock),
    .convert_strobe(convert_strobe), .serial_in(serial_in), .sample_code(sample_code),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .conv_busy(conv_busy));
  task automatic final_report();
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      final_report();
    end
  end
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle();
    repeat (4) @(negedge sys_clk);
  endtask
  // Starts a conversion and times the busy window
  task automatic convert(input logic [17:0] code, input logic sel, input logic glitch,
                         input logic arm);
    int n;
    n = 0;
    @(negedge sys_clk) sample_code = code;
    u_host.strobe(1'b1, sel);
    while (conv_busy !== 1'b1 && n < 20) @(negedge sys_clk) n++;
    if (glitch) begin
      u_host.strobe(1'b0, sel);
      u_host.strobe(1'b1, sel);
    end
    if (arm)
      u_host.strobe(1'b1, 1'b0);
    n = 0;
    while (conv_busy === 1'b1 && n < 40) begin
      if (arm && n == 6)
        check(18'({serial_out_oe, serial_out}), 18'h0_0002);
      @(negedge sys_clk) n++;
    end
    check(18'(n), 18'(asrms_pkg::CONV_CYC));
  endtask
  task automatic chain_read();
    logic [17:0] r;
    convert(18'h2_A5C3, 1'b0, 1'b1, 1'b0);
    u_host.shift(3, 36'h0_0000_0000);
    // Strobe stays high through the whole chain read
    u_host.shift(36, 36'h0_0003_5C96);
    r = {<<{u_host.q[17:0]}};
    check(r, 18'h2_A5C3);
    check(u_host.q[35:18], 18'h3_5C96);
    u_host.strobe(1'b0, 1'b1);
  endtask
  task automatic framed_strobe();
    logic [17:0] r;
    convert(18'h1_0F3C, 1'b1, 1'b0, 1'b0);
    u_host.strobe(1'b0, 1'b1);
    settle();
    check(18'(serial_out_oe), 18'h0_0001);
    u_host.shift(3, 36'hF_FFFF_FFFF);
    u_host.shift(18, 36'hF_FFFF_FFFF);
    r = {<<{u_host.q[17:0]}};
    check(r, 18'h1_0F3C);
    settle();
    check(18'(serial_out_oe), 18'h0_0000);
  endtask
  task automatic framed_busy();
    convert(18'h3_C3A5, 1'b1, 1'b0, 1'b1);
    settle();
    check(18'(serial_out), 18'h0_0001);
    u_host.shift(3, 36'h0_0000_0000);
    u_host.shift(5, 36'h0_0000_0000);
    check(18'(u_host.q[4:0]), 18'h0_000F);
    u_host.strobe(1'b1, 1'b1);
    settle();
    check(18'(serial_out_oe), 18'h0_0000);
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    check(18'({serial_out_oe, conv_busy}), 18'h0_0000);
    // Link side has no reset, so flush it with a few idle shifts
    u_host.shift(4, 36'h0_0000_0000);
    chain_read();
    framed_strobe();
    framed_busy();
    final_report();
  end
endmodule // test_asrms_top
